// File: inc/fcnt_pkg.sv
// fill-level counter package: register map, control fields, constants.
// assumes an apb master on the core clock and user logic on the same clock.

package fcnt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DCNT_OFS = 8'h08;
  localparam logic [7:0] WCNT_OFS = 8'h0c;
  localparam logic [7:0] RCNT_OFS = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CTRL_INDEP_BIT = 0;
  localparam int CTRL_LOOK_BIT = 1;
  localparam int CTRL_ACC_BIT = 2;
  localparam int CTRL_FLUSH_BIT = 3;
  localparam logic CTRL_INDEP_RST = 1'b1;
  localparam logic CTRL_LOOK_RST = 1'b0;
  localparam logic CTRL_ACC_RST = 1'b0;

  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_STAGE_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [1:0] LOOK_EXTRA = 2'h2;
  localparam int SYNC_STAGES = 2;

  typedef enum {
    FCNT_BRAM,
    FCNT_DRAM,
    FCNT_SHREG,
    FCNT_HARD
  } fcnt_impl_t;

endpackage

// File: logic/fcnt_mem.sv
// storage array for the fifo, one write and one read port.
// assumes one clock; read data come out of a register updated on i_re.
`timescale 1ns/1ps

module fcnt_mem #(
  parameter int DATA_W = 8,
  parameter int AW = 4
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [DATA_W-1:0] o_rdata
);

  logic [DATA_W-1:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents are don't-care until written
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// File: logic/fcnt_top.sv
// fifo with occupancy counters for common and independent clock modes,
// standard or lookahead reads, approximate or accurate count schemes.
// assumes user logic and an apb master on i_core_clk; the independent
// mode keeps its two pointer sides apart through gray synchronisers.
//
// Design decisions made here: the register decode and register access over APB.
`timescale 1ns/1ps

module fcnt_top #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5,
  parameter bit HAS_COUNTS = 1'b1,
  parameter fcnt_pkg::fcnt_impl_t IMPL = fcnt_pkg::FCNT_BRAM
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [fcnt_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // user write side
  input wire logic i_wr_en,
  input wire logic [DATA_W-1:0] i_wr_data,
  output logic o_full,
  output logic [CNT_W-1:0] o_wr_count,
  // user read side
  input wire logic i_rd_en,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_empty,
  output logic [CNT_W-1:0] o_rd_count,
  // common clock fill count
  output logic [CNT_W-1:0] o_data_count
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] CAP = AW'(DEPTH - 1);
  localparam logic [AW:0] SAT = (AW+1)'(DEPTH - 1);
  // hard fifo builds carry no counters at all
  localparam bit COUNTS_ON = HAS_COUNTS && (IMPL != fcnt_pkg::FCNT_HARD);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fcnt_top: DEPTH must be a power of two, at least 4");
  end
  if (CNT_W < 1 || CNT_W > AW + 1) begin : g_bad_cnt
    $error("fcnt_top: CNT_W must lie between 1 and log2(DEPTH)+1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [AW-1:0] to_gray(input logic [AW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [AW-1:0] from_gray(input logic [AW-1:0] g);
    logic [AW-1:0] b;
    b = '0;
    for (int i = 0; i < AW; i++) begin
      b[i] = ^(g >> i);
    end
    return b;
  endfunction

  // keep the top bits of the full-width count; accurate counts are one
  // bit wider, so their msb sits one place higher
  function automatic logic [CNT_W-1:0] trunc(input logic [AW:0] v,
                                             input logic accw);
    int w;
    int lsb;
    logic [CNT_W-1:0] r;
    r = '0;
    w = accw ? CNT_W : ((CNT_W > AW) ? AW : CNT_W);
    lsb = accw ? (AW + 1 - w) : (AW - w);
    for (int i = 0; i < CNT_W; i++) begin
      if (i < w) begin
        r[i] = v[lsb+i];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic indep;
  logic look;
  logic acc;
  logic flush;
  logic clr;
  logic apb_setup;
  logic apb_wr;
  logic acc_eff;

  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr = i_psel & i_penable & i_pwrite;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      indep <= fcnt_pkg::CTRL_INDEP_RST;
      look <= fcnt_pkg::CTRL_LOOK_RST;
      acc <= fcnt_pkg::CTRL_ACC_RST;
    end else if (apb_wr && i_paddr == fcnt_pkg::CTRL_OFS) begin
      indep <= i_pwdata[fcnt_pkg::CTRL_INDEP_BIT];
      look <= i_pwdata[fcnt_pkg::CTRL_LOOK_BIT];
      acc <= i_pwdata[fcnt_pkg::CTRL_ACC_BIT];
    end
  end

  // flush is a one-cycle self-clearing strobe that acts like reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      flush <= 1'b0;
    end else begin
      flush <= apb_wr && i_paddr == fcnt_pkg::CTRL_OFS &&
               i_pwdata[fcnt_pkg::CTRL_FLUSH_BIT];
    end
  end

  assign clr = !i_rstn || flush;

  // common clock has no approximate scheme, so lookahead there is accurate
  assign acc_eff = look & (acc | ~indep);

  ////////////////////////////////////////////////////////////////////////////
  // pointers and gray crossing

  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW-1:0] wgray;
  logic [AW-1:0] rgray;
  logic [AW-1:0] wsync1;
  logic [AW-1:0] wsync2;
  logic [AW-1:0] rsync1;
  logic [AW-1:0] rsync2;
  logic [AW-1:0] rptr_seen;
  logic [AW-1:0] wptr_seen;
  logic [AW-1:0] wr_used;
  logic [AW-1:0] rd_avail;
  logic mem_empty;
  logic wr_go;
  logic fetch;

  // gray copies come from flops so the synchronisers never see glitches
  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      wgray <= '0;
      rgray <= '0;
      wsync1 <= '0;
      wsync2 <= '0;
      rsync1 <= '0;
      rsync2 <= '0;
    end else begin
      wgray <= to_gray(wptr);
      rgray <= to_gray(rptr);
      wsync1 <= wgray;
      wsync2 <= wsync1;
      rsync1 <= rgray;
      rsync2 <= rsync1;
    end
  end

  // in independent mode each side compares its own pointer to the other's delayed copy; the
  // lag only ever makes the write side high and the read side low
  assign rptr_seen = indep ? from_gray(rsync2) : rptr;
  assign wptr_seen = indep ? from_gray(wsync2) : wptr;
  assign wr_used = wptr - rptr_seen;
  assign rd_avail = wptr_seen - rptr;
  assign mem_empty = (rd_avail == '0);
  assign o_full = (wr_used == CAP);
  assign wr_go = i_wr_en & ~o_full;

  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      wptr <= '0;
    end else if (wr_go) begin
      wptr <= wptr + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      rptr <= '0;
    end else if (fetch) begin
      rptr <= rptr + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [DATA_W-1:0] mem_q;

  fcnt_mem #(
    .DATA_W(DATA_W),
    .AW(AW)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_we(wr_go),
    .i_waddr(wptr),
    .i_wdata(i_wr_data),
    .i_re(fetch),
    .i_raddr(rptr),
    .o_rdata(mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read side: standard or lookahead stage of two words

  logic [1:0] stg_n;
  logic inflight;
  logic pop;
  logic rd_vld_q;
  logic [DATA_W-1:0] st0;
  logic [DATA_W-1:0] st1;
  logic [1:0] slot;

  assign pop = look & i_rd_en & (stg_n != 2'h0);
  assign slot = stg_n - {1'b0, pop};

  // lookahead prefetches until the stage plus the word in flight make two;
  // it does not refill a full stage in its pop cycle, trading one cycle of throughput
  // for a simpler slot choice
  always_comb begin
    if (look) begin
      fetch = ~mem_empty &&
              ({1'b0, stg_n} + {2'b0, inflight}) < {1'b0, fcnt_pkg::LOOK_EXTRA};
    end else begin
      fetch = i_rd_en & ~mem_empty;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      inflight <= 1'b0;
      rd_vld_q <= 1'b0;
    end else begin
      inflight <= fetch & look;
      rd_vld_q <= fetch & ~look;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      stg_n <= 2'h0;
    end else begin
      stg_n <= stg_n - {1'b0, pop} + {1'b0, inflight};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      st0 <= '0;
      st1 <= '0;
    end else begin
      if (inflight && slot == 2'h0) begin
        st0 <= mem_q;
      end else if (pop) begin
        st0 <= st1;
      end
      if (inflight && slot == 2'h1) begin
        st1 <= mem_q;
      end
    end
  end

  // switching lookahead off with words staged loses them; flush first
  assign o_rd_data = look ? st0 : mem_q;
  assign o_rd_valid = look ? (stg_n != 2'h0) : rd_vld_q;
  assign o_empty = look ? (stg_n == 2'h0) : mem_empty;

  ////////////////////////////////////////////////////////////////////////////
  // counts

  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [AW:0] next_fill;
  logic [AW:0] wr_val;
  logic [AW:0] rd_raw;
  logic [AW:0] rd_val;

  assign next_wptr = wptr + {{(AW-1){1'b0}}, wr_go};
  assign next_rptr = rptr + {{(AW-1){1'b0}}, fetch};

  // the accurate fill counts the stage as always full: exact once the
  // stage is loaded, up to two high near empty, and 2 when empty
  assign next_fill = {1'b0, next_wptr - next_rptr} +
                     (look ? {{(AW-1){1'b0}}, fcnt_pkg::LOOK_EXTRA} : '0);

  // built from next pointers, so it moves on the operation's own edge
  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      o_data_count <= '0;
    end else if (COUNTS_ON && !indep) begin
      o_data_count <= trunc(next_fill, acc_eff);
    end else begin
      o_data_count <= '0;
    end
  end

  // accurate write count assumes two staged read words even when they are
  // not there; it lands on the true count once the stage fills
  assign wr_val = {1'b0, wr_used} +
                  (acc_eff ? {{(AW-1){1'b0}}, fcnt_pkg::LOOK_EXTRA} : '0);

  assign rd_raw = {1'b0, rd_avail} + (look ? {{(AW-1){1'b0}}, stg_n} : '0);
  // approximate counts keep the plain width and stop at depth minus one
  assign rd_val = (!acc_eff && rd_raw > SAT) ? SAT : rd_raw;

  // sampled from current pointers, so each change shows one cycle later
  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      o_wr_count <= '0;
    end else if (COUNTS_ON && indep) begin
      o_wr_count <= trunc(wr_val, acc_eff);
    end else begin
      o_wr_count <= '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (clr) begin
      o_rd_count <= '0;
    end else if (COUNTS_ON && indep) begin
      o_rd_count <= trunc(rd_val, acc_eff);
    end else begin
      o_rd_count <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read path: decoded in the setup cycle, answered in access

  logic [31:0] rd_word;
  logic rd_err;
  logic pslverr_q;

  always_comb begin
    rd_word = '0;
    rd_err = 1'b0;
    case (i_paddr)
      fcnt_pkg::CTRL_OFS: begin
        rd_word[fcnt_pkg::CTRL_INDEP_BIT] = indep;
        rd_word[fcnt_pkg::CTRL_LOOK_BIT] = look;
        rd_word[fcnt_pkg::CTRL_ACC_BIT] = acc;
      end
      fcnt_pkg::STAT_OFS: begin
        rd_word[fcnt_pkg::STAT_EMPTY_BIT] = o_empty;
        rd_word[fcnt_pkg::STAT_FULL_BIT] = o_full;
        rd_word[fcnt_pkg::STAT_STAGE_LSB +: 2] = stg_n;
      end
      fcnt_pkg::DCNT_OFS: begin
        rd_word[CNT_W-1:0] = o_data_count;
      end
      fcnt_pkg::WCNT_OFS: begin
        rd_word[CNT_W-1:0] = o_wr_count;
      end
      fcnt_pkg::RCNT_OFS: begin
        rd_word[CNT_W-1:0] = o_rd_count;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_prdata <= '0;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
      pslverr_q <= rd_err;
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = pslverr_q & i_psel & i_penable;

endmodule

// File: verif/fcnt_assertions.sv
// checker for the fill-level counters, watching top ports only.
// assumes mode changes always carry the flush bit in the same write.
`timescale 1ns/1ps

module fcnt_checker #(
  parameter int CNT_W = 5
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [fcnt_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic i_wr_en,
  input wire logic o_full,
  input wire logic i_rd_en,
  input wire logic o_empty,
  input wire logic [CNT_W-1:0] o_wr_count,
  input wire logic [CNT_W-1:0] o_rd_count,
  input wire logic [CNT_W-1:0] o_data_count
);
  logic indep, look, acc, ctl_wr, wr_ok, rd_ok, ok;
  logic [5:0] occ;
  logic [2:0] iw, ir, st;
  assign ctl_wr = i_psel && i_penable && i_pwrite && o_pready &&
    i_paddr == fcnt_pkg::CTRL_OFS;
  assign wr_ok = i_wr_en && !o_full;
  assign rd_ok = i_rd_en && !o_empty;
  // counts are only judged once a flush has fully settled
  assign ok = st == 3'h7;
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      indep <= fcnt_pkg::CTRL_INDEP_RST;
      look <= fcnt_pkg::CTRL_LOOK_RST;
      acc <= fcnt_pkg::CTRL_ACC_RST;
    end else if (ctl_wr) begin
      indep <= i_pwdata[fcnt_pkg::CTRL_INDEP_BIT];
      look <= i_pwdata[fcnt_pkg::CTRL_LOOK_BIT];
      acc <= i_pwdata[fcnt_pkg::CTRL_ACC_BIT];
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn || ctl_wr) begin
      occ <= 6'h00;
      st <= 3'h0;
    end else begin
      occ <= occ + 6'(wr_ok) - 6'(rd_ok);
      if (!ok) st <= st + 3'h1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      iw <= 3'h7;
      ir <= 3'h7;
    end else begin
      iw <= wr_ok ? 3'h0 : (iw == 3'h7 ? iw : iw + 3'h1);
      ir <= rd_ok ? 3'h0 : (ir == 3'h7 ? ir : ir + 3'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  chk_fill_up:
    assert property (ok && !indep && !look && wr_ok && !rd_ok
      |=> o_data_count == $past(o_data_count) + 1)
    else $error("fill count missed a write");
  chk_fill_down:
    assert property (ok && !indep && !look && rd_ok && !wr_ok
      |=> o_data_count == $past(o_data_count) - 1)
    else $error("fill count missed a read");
  chk_rd_lag:
    assert property (ok && indep && !look && rd_ok && ir != 0 && iw >= 6
      |=> ##1 o_rd_count == $past(o_rd_count, 2) - 1)
    else $error("read count late after read");
  chk_wr_lag:
    assert property (ok && indep && !look && wr_ok && iw != 0 && ir >= 6
      |=> ##1 o_wr_count == $past(o_wr_count, 2) + 1)
    else $error("write count late after write");
  chk_rd_bound:
    assert property (ok && indep && !look |-> o_rd_count <= $past(occ))
    else $error("read count above stored words");
  chk_wr_bound:
    assert property (ok && indep && !look |-> o_wr_count >= $past(occ))
    else $error("write count below stored words");
  chk_rst_zero:
    assert property (disable iff (1'b0) !i_rstn |=> o_wr_count == 0 &&
      o_data_count == 0 && o_rd_count == 0)
    else $error("counts not cleared by reset");
  chk_approx_cap:
    assert property (ok && indep && !acc
      |-> o_rd_count <= 15 && o_wr_count <= 15)
    else $error("approximate count above ceiling");
  // settled and holding all seventeen words, the read count must pin at 15
  chk_approx_sat:
    assert property (ok && indep && look && !acc && occ == 17 && iw == 7 &&
      ir == 7 |-> o_rd_count == 15)
    else $error("approximate read count not saturated");
  chk_look_empty:
    assert property (ok && !indep && look && occ == 0 |-> o_data_count == 2)
    else $error("empty lookahead fill count not two");
  chk_wr_empty:
    assert property (ok && indep && look && acc && occ == 0 && iw == 7 &&
      ir == 7 |-> o_wr_count == 2)
    else $error("empty accurate write count not two");
endmodule

bind fcnt_top fcnt_checker #(.CNT_W(CNT_W)) fcnt_checker_inst (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .i_wr_en(i_wr_en),
  .o_full(o_full), .i_rd_en(i_rd_en), .o_empty(o_empty),
  .o_wr_count(o_wr_count), .o_rd_count(o_rd_count),
  .o_data_count(o_data_count));

// File: verif/fcnt_user.sv
// user logic on the far side: writes and reads on command.
// assumes one clock shared with the fifo.
`timescale 1ns/1ps

module fcnt_user #(
  parameter int CNT_W = 5,
  parameter int DATA_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_go_wr,
  input wire logic i_go_rd,
  input wire logic i_full,
  input wire logic i_empty,
  input wire logic [CNT_W-1:0] i_count,
  output logic o_wr_en,
  output logic [DATA_W-1:0] o_wr_data,
  output logic o_rd_en,
  output logic o_half
);
  // writes are not gated by full on purpose, so refusals get exercised
  assign o_wr_en = i_go_wr;
  assign o_rd_en = i_go_rd && !i_empty;
  // with wide counts no single bit tells half full
  assign o_half = i_count[CNT_W-1] | i_count[CNT_W-2];
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) o_wr_data <= '0;
    else if (o_wr_en && !i_full) o_wr_data <= o_wr_data + 1'b1;
  end
endmodule

// File: verif/fifo_fill_level_counters_bench.sv
// self-checking bench for the fill-level counters over apb.
// assumes zero-wait apb and the user model driving the fifo ports.
`timescale 1ns/1ps

module fifo_fill_level_counters_bench;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, full, empty, rvalid, wr_en, rd_en, half;
  logic go_wr = 1'b0, go_rd = 1'b0;
  logic [7:0] wdata, rdata;
  logic [4:0] wcnt, rcnt, dcnt;
  int fail_count = 0, comparisons = 0, cyc = 0;
  // ctrl, writes, reads, fill, write-side, read-side
  int rows [9][6] = '{'{0, 5, 2, 3, 0, 0}, '{0, 20, 0, 15, 0, 0},
    '{1, 7, 3, 0, 4, 4}, '{1, 20, 0, 0, 15, 15}, '{3, 0, 0, 0, 0, 0},
    '{3, 20, 0, 0, 15, 15}, '{7, 0, 0, 0, 2, 0}, '{6, 0, 0, 2, 0, 0},
    '{6, 5, 0, 5, 0, 0}};
  always #12.5 clk = ~clk;
  fcnt_top fcnt_top_inst (.i_core_clk(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_wr_en(wr_en), .i_wr_data(wdata), .o_full(full), .o_wr_count(wcnt),
    .i_rd_en(rd_en), .o_rd_data(rdata), .o_rd_valid(rvalid),
    .o_empty(empty), .o_rd_count(rcnt), .o_data_count(dcnt));
  fcnt_user fcnt_user_inst (.i_core_clk(clk), .i_rstn(rstn),
    .i_go_wr(go_wr), .i_go_rd(go_rd), .i_full(full), .i_empty(empty),
    .i_count(dcnt), .o_wr_en(wr_en), .o_wr_data(wdata), .o_rd_en(rd_en),
    .o_half(half));
  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // the request stands until pready is seen high at a rising edge; read
  // data and error are taken at that same edge, then the bus is released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task run(input int nw, input int nr);
    if (nw > 0) begin
      @(posedge clk) go_wr <= 1'b1;
      tk(nw);
      go_wr <= 1'b0;
    end
    tk(8);
    if (nr > 0) begin
      @(posedge clk) go_rd <= 1'b1;
      tk(nr);
      go_rd <= 1'b0;
    end
    tk(10);
  endtask
  initial begin
    tk(16);
    rstn <= 1'b1;
    apb(1'b0, fcnt_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    chk(rcnt, 5'h00);
    $display("reset defaults done");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, fcnt_pkg::CTRL_OFS, 32'(rows[i][0]) | 32'h8);
      tk(8);
      run(rows[i][1], rows[i][2]);
      apb(1'b0, fcnt_pkg::DCNT_OFS, 32'h0);
      chk(rd, rows[i][3]);
      apb(1'b0, fcnt_pkg::WCNT_OFS, 32'h0);
      chk(rd, rows[i][4]);
      chk(rcnt, rows[i][5]);
      chk(half, rows[i][3] >= 8);
      chk(full, rows[i][1] == 20);
      $display("row %0d done", i);
    end
    // last row leaves five words: two staged, three in memory
    apb(1'b0, fcnt_pkg::STAT_OFS, 32'h0);
    chk(rd, 32'h8);
    $display("lookahead stage done");
    run(4, 0);
    @(posedge clk) rstn <= 1'b0;
    tk(2);
    chk(dcnt, 5'h00);
    chk(wcnt, 5'h00);
    rstn <= 1'b1;
    $display("mid-run reset done");
    run(2, 0);
    @(posedge clk) go_rd <= 1'b1;
    @(posedge clk) go_rd <= 1'b0;
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, 8'h00);
    tk(3);
    chk(rcnt, 5'h01);
    $display("read latency done");
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("unmapped access done");
    report_and_stop;
  end
endmodule
